// ---- rtl/mbc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mbc_regs.svh"
module mbc_top #(
    parameter int BANKS = 9
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // system side
    input  wire logic [33:0] system_address,
    input  wire logic        row_strobe_request,
    input  wire logic        refresh_active,
    input  wire logic        serial_load_start,
    input  wire logic        serial_load_active,
    input  wire logic        memory_width_pin,
    // memory side
    output logic [8:0]       bank_select,
    output logic             bank_hit,
    output logic             bank_miss,
    output logic             subset_select,
    output logic [3:0]       row_address_bits,
    output logic [3:0]       column_address_bits,
    output logic             error_check_active,
    output logic [8:0]       primary_row_strobe_n,
    output logic [8:0]       secondary_row_strobe_n,
    output logic [8:0]       serial_row_address,
    output logic [6:0]       serial_column_address,
    // presence detect shifter pins
    input  wire logic        pd_serial_data,
    output logic             pd_load,
    output logic             pd_shift_clock
);
    if (BANKS != 9) begin : g_chk
        $error("decode needs nine banksets");
    end

    localparam int VB = BANKS - 1;

    ////////////////////////////////////////////////////////////////////////
    // register storage
    mbc_pkg::mbc_word_t cfg [BANKS];
    mbc_pkg::mbc_word_t next_cfg [BANKS];
    mbc_pkg::mbc_base_t base [BANKS];
    mbc_pkg::mbc_base_t next_base [BANKS];
    logic [14:0]        video_frame_start_pointer;
    logic [14:0]        next_vfp;
    logic [14:0]        display_pointer;
    logic [14:0]        next_display_pointer;
    logic [31:0]        pd_data;
    logic               pd_valid;

    // axi state
    logic               aw_full;
    logic               next_aw_full;
    logic [7:0]         aw_addr;
    logic [7:0]         next_aw_addr;
    logic               w_full;
    logic               next_w_full;
    logic [31:0]        w_data;
    logic [31:0]        next_w_data;
    logic [3:0]         w_strb;
    logic [3:0]         next_w_strb;
    logic               next_awready;
    logic               next_wready;
    logic               next_bvalid;
    logic [1:0]         next_bresp;
    logic               next_arready;
    logic               next_rvalid;
    logic [31:0]        next_rdata;
    logic [1:0]         next_rresp;
    logic               do_write;

    mbc_pd_shift u_pd (
        .mclk           (mclk),
        .sys_rst        (sys_rst),
        .pd_serial_data (pd_serial_data),
        .pd_load        (pd_load),
        .pd_shift_clock (pd_shift_clock),
        .pd_data        (pd_data),
        .pd_valid       (pd_valid)
    );

    // merge low byte lanes
    function automatic mbc_pkg::mbc_word_t merge16(input mbc_pkg::mbc_word_t old,
                                                   input logic [31:0] d,
                                                   input logic [3:0] s);
        mbc_pkg::mbc_word_t r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction : merge16

    // read mux, bit 32 = mapped
    function automatic logic [32:0] read_reg(input logic [7:0] a);
        logic [32:0] r;
        int          i;
        r = {1'b1, 32'h0000_0000};
        unique case (a)
            `MBC_OFF_VFP:     r[14:0] = video_frame_start_pointer;
            `MBC_OFF_PD_LOW:  r[15:0] = pd_data[15:0];
            `MBC_OFF_PD_HIGH: r[15:0] = pd_data[31:16];
            `MBC_OFF_STATUS:  r[0] = pd_valid;
            default: begin
                r[32] = 1'b0;
                for (i = 0; i < BANKS; i++) begin
                    if (a == 8'(`MBC_OFF_CFG_BASE + 4 * i)) begin
                        r = {1'b1, 16'h0000, cfg[i] & ((i == VB) ? 16'h03FF : 16'h01FF)};
                    end
                    if (a == 8'(`MBC_OFF_BASE_BASE + 4 * i)) begin
                        r = {1'b1, 18'h00000, base[i]};
                    end
                end
            end
        endcase
        return r;
    endfunction : read_reg

    ////////////////////////////////////////////////////////////////////////
    // axi channels; aw and w in any order
    always_comb begin
        logic [32:0] rd;
        logic [32:0] wd;
        rd           = read_reg(s_axi_araddr);
        wd           = read_reg(aw_addr);
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full  = w_full;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        do_write     = aw_full && w_full && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wd[32] ? `MBC_RESP_OKAY : `MBC_RESP_SLVERR;
        end
        next_awready = !next_aw_full;
        next_wready  = !next_w_full;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = rd[31:0];
            next_rresp   = rd[32] ? `MBC_RESP_OKAY : `MBC_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_full       <= 1'b0;
            aw_addr       <= 8'h00;
            w_full        <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            aw_full       <= next_aw_full;
            aw_addr       <= next_aw_addr;
            w_full        <= next_w_full;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            // ready rises after reset
            s_axi_arready <= next_arready | (!s_axi_arready && !s_axi_rvalid);
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writes, display pointer load
    always_comb begin
        int i;
        next_vfp             = video_frame_start_pointer;
        next_display_pointer = display_pointer;
        for (i = 0; i < BANKS; i++) begin
            next_cfg[i]  = cfg[i];
            next_base[i] = base[i];
        end
        if (do_write) begin
            if (aw_addr == `MBC_OFF_VFP) begin
                next_vfp = 15'(merge16({1'b0, video_frame_start_pointer}, w_data, w_strb));
            end
            for (i = 0; i < BANKS; i++) begin
                if (aw_addr == 8'(`MBC_OFF_CFG_BASE + 4 * i)) begin
                    next_cfg[i] = merge16(cfg[i], w_data, w_strb);
                end
                if (aw_addr == 8'(`MBC_OFF_BASE_BASE + 4 * i)) begin
                    next_base[i] = 14'(merge16({2'b00, base[i]}, w_data, w_strb));
                end
            end
        end
        if (serial_load_start) begin
            next_display_pointer = video_frame_start_pointer;
        end
    end

    // only valid, subbank enable and video size and check are reset
    always_ff @(posedge mclk) begin
        video_frame_start_pointer <= next_vfp;
        display_pointer           <= next_display_pointer;
        for (int i = 0; i < BANKS; i++) begin
            cfg[i]  <= next_cfg[i];
            base[i] <= next_base[i];
        end
        if (sys_rst) begin
            for (int i = 0; i < BANKS; i++) begin
                cfg[i][`MBC_CFG_VALID]  <= `MBC_RST_VALID;
                cfg[i][`MBC_CFG_SUBENA] <= `MBC_RST_SUBENA;
            end
            cfg[VB][`MBC_CFG_SIZE_MSB:`MBC_CFG_SIZE_LSB] <= `MBC_RST_SIZE8;
            cfg[VB][`MBC_CFG_CHECK]                      <= `MBC_RST_CHECK8;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-bankset address compare
    logic [BANKS-1:0] hit_vec;
    logic [BANKS-1:0] sub_vec;

    for (genvar g = 0; g < BANKS; g++) begin : g_bank
        logic [5:0] lsb;
        logic       code_ok;
        logic       match;
        always_comb begin
            logic [3:0] code;
            code    = cfg[g][`MBC_CFG_SIZE_MSB:`MBC_CFG_SIZE_LSB];
            lsb     = 6'd20;
            code_ok = 1'b0;
            if (g < VB) begin
                // 512 MB down to 8 MB
                if (code >= 4'h1 && code <= 4'h7) begin
                    code_ok = 1'b1;
                    lsb     = 6'd30 - {2'b00, code};
                end
            end else begin
                if (code >= 4'h9 && code <= 4'hC) begin
                    code_ok = 1'b1;
                    lsb     = 6'd32 - {2'b00, code};
                end
            end
            match = 1'b1;
            for (int b = 0; b < 14; b++) begin
                if (6'(b + `MBC_BASE_ADDR_LSB) >= lsb &&
                    system_address[b + `MBC_BASE_ADDR_LSB] != base[g][b]) begin
                    match = 1'b0;
                end
            end
        end
        assign hit_vec[g] = cfg[g][`MBC_CFG_VALID] && code_ok && match;
        assign sub_vec[g] = system_address[lsb - 6'd1];
    end

    ////////////////////////////////////////////////////////////////////////
    // select, widths and strobes
    logic [8:0] next_sel;
    logic       next_sub;
    logic [3:0] next_rows;
    logic [3:0] next_cols;
    logic [8:0] next_prim_n;
    logic [8:0] next_sec_n;

    always_comb begin
        logic [2:0] cs;
        logic       use_b8;
        next_sel  = 9'h000;
        next_sub  = 1'b0;
        cs        = 3'h0;
        // lowest bankset wins
        for (int i = BANKS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                next_sel = 9'h001 << i;
                next_sub = sub_vec[i];
                cs       = cfg[i][`MBC_CFG_COLSEL_MSB:`MBC_CFG_COLSEL_LSB];
            end
        end
        next_rows = 4'h0;
        next_cols = 4'h0;
        if (next_sel[VB]) begin
            if (cs == 3'h4) {next_rows, next_cols} = {4'h9, 4'h9};
            if (cs == 3'h5) {next_rows, next_cols} = {4'h9, 4'h8};
        end else if (next_sel != 9'h000) begin
            if (cs == 3'h0) {next_rows, next_cols} = {4'hC, 4'hC};
            if (cs == 3'h1) {next_rows, next_cols} = memory_width_pin ? {4'hB, 4'hB}
                                                                     : {4'hC, 4'hA};
            if (cs == 3'h3) {next_rows, next_cols} = {4'hA, 4'hA};
        end
        use_b8 = cfg[VB][`MBC_CFG_SUBENA] && display_pointer[`MBC_VFP_SUB];
        for (int i = 0; i < BANKS; i++) begin
            next_prim_n[i] = !(row_strobe_request && next_sel[i] &&
                               !(cfg[i][`MBC_CFG_SUBENA] && next_sub));
            next_sec_n[i]  = !(row_strobe_request && next_sel[i] &&
                               cfg[i][`MBC_CFG_SUBENA] && next_sub);
            if (refresh_active && cfg[i][`MBC_CFG_VALID]) begin
                next_prim_n[i] = 1'b0;
                next_sec_n[i]  = 1'b0;
            end
        end
        if (serial_load_active && cfg[VB][`MBC_CFG_VALID]) begin
            next_prim_n[VB] = use_b8;
            next_sec_n[VB]  = !use_b8;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bank_select            <= 9'h000;
            bank_hit               <= 1'b0;
            bank_miss              <= 1'b0;
            subset_select          <= 1'b0;
            row_address_bits       <= 4'h0;
            column_address_bits    <= 4'h0;
            error_check_active     <= 1'b1;
            primary_row_strobe_n   <= 9'h1FF;
            secondary_row_strobe_n <= 9'h1FF;
            serial_row_address     <= 9'h000;
            serial_column_address  <= 7'h00;
        end else begin
            bank_select            <= next_sel;
            bank_hit               <= next_sel != 9'h000;
            bank_miss              <= row_strobe_request && next_sel == 9'h000;
            subset_select          <= next_sub;
            row_address_bits       <= next_rows;
            column_address_bits    <= next_cols;
            error_check_active     <= !next_sel[VB] || cfg[VB][`MBC_CFG_CHECK];
            primary_row_strobe_n   <= next_prim_n;
            secondary_row_strobe_n <= next_sec_n;
            serial_row_address     <= display_pointer[`MBC_VFP_ROW_MSB:`MBC_VFP_ROW_LSB];
            serial_column_address  <= {display_pointer[`MBC_VFP_COL_MSB:`MBC_VFP_COL_LSB],
                                       2'b00};
        end
    end
endmodule : mbc_top
`default_nettype wire

// ---- rtl/mbc_regs.svh ----
// Functional notes
// - each bankset has a config word; video bankset 8 has its own format
// - full serial transfer start copies frame pointer to display pointer
// - frame pointer bits 4:0 drive serial column address 6:2
// - frame pointer bits 13:5 give the frame start row
// - bit 14 picks bankset 8 secondary strobe if its subbanks on
// - first sixteen presence bits in presence_detect_low
// - presence bits 31:16 in presence_detect_high 15:0
// - presence data valid 148 clocks after reset release
// - only valid banksets compare base with system address
// - config bit 0 valid flag, reset 0, blocks access while clear
// - frame pointer and config fields other than valid, subbank enable and bankset 8 size and check are not reset
// - size codes 1..7 give 512 MB to 8 MB decode
// - subbank enable resets 0; when clear secondary strobe only on refresh
// - column select and width pin give row and column widths
`ifndef MBC_REGS_SVH
`define MBC_REGS_SVH

// byte offsets
`define MBC_OFF_VFP         8'h00
`define MBC_OFF_PD_LOW      8'h04
`define MBC_OFF_PD_HIGH     8'h08
`define MBC_OFF_STATUS      8'h0C
`define MBC_OFF_CFG_BASE    8'h10
`define MBC_OFF_BASE_BASE   8'h40

// configuration word fields
`define MBC_CFG_VALID       0
`define MBC_CFG_SIZE_LSB    1
`define MBC_CFG_SIZE_MSB    4
`define MBC_CFG_SUBENA      5
`define MBC_CFG_COLSEL_LSB  6
`define MBC_CFG_COLSEL_MSB  8
`define MBC_CFG_CHECK       9

// frame pointer fields
`define MBC_VFP_COL_LSB     0
`define MBC_VFP_COL_MSB     4
`define MBC_VFP_ROW_LSB     5
`define MBC_VFP_ROW_MSB     13
`define MBC_VFP_SUB         14

// base holds address 33:20
`define MBC_BASE_ADDR_LSB   20

// reset values
`define MBC_RST_VALID       1'b0
`define MBC_RST_SUBENA      1'b0
`define MBC_RST_SIZE8       4'h0
`define MBC_RST_CHECK8      1'b0

// presence timing, mclk
`define MBC_PD_VALID_CYCLES 148
`define MBC_PD_BITS         32
`define MBC_PD_BIT_CYCLES   4
`define MBC_PD_LEAD_CYCLES  (`MBC_PD_VALID_CYCLES - `MBC_PD_BITS * `MBC_PD_BIT_CYCLES)

// axi responses
`define MBC_RESP_OKAY       2'h0
`define MBC_RESP_SLVERR     2'h2

`endif

// ---- rtl/mbc_pkg.sv ----
package mbc_pkg;
    typedef logic [15:0] mbc_word_t;
    typedef logic [13:0] mbc_base_t;
    typedef logic [3:0]  mbc_width_t;
    typedef enum logic [1:0] {
        MBC_PD_LEAD  = 2'b00,
        MBC_PD_SHIFT = 2'b01,
        MBC_PD_DONE  = 2'b10
    } mbc_pd_state_t;
endpackage : mbc_pkg

// ---- rtl/mbc_pd_shift.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mbc_regs.svh"
module mbc_pd_shift #(
    parameter int BIT_CYCLES = `MBC_PD_BIT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        pd_serial_data,
    output logic             pd_load,
    output logic             pd_shift_clock,
    output logic [31:0]      pd_data,
    output logic             pd_valid
);
    localparam int LEAD = `MBC_PD_VALID_CYCLES - `MBC_PD_BITS * BIT_CYCLES;

    if (BIT_CYCLES < 2 || LEAD < 1) begin : g_chk
        $error("bit period too long");
    end

    mbc_pkg::mbc_pd_state_t state;
    mbc_pkg::mbc_pd_state_t next_state;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [5:0]  bits;
    logic [5:0]  next_bits;
    logic [31:0] next_pd_data;
    logic        next_pd_load;
    logic        next_pd_shift_clock;
    logic        next_pd_valid;

    ////////////////////////////////////////////////////////////////////////
    // load shifter, then 32 bits lsb first
    always_comb begin
        next_state          = state;
        next_cnt            = cnt + 8'h01;
        next_bits           = bits;
        next_pd_data        = pd_data;
        next_pd_load        = 1'b0;
        next_pd_shift_clock = 1'b0;
        next_pd_valid       = pd_valid;
        unique case (state)
            mbc_pkg::MBC_PD_LEAD: begin
                next_pd_load = 1'b1;
                if (cnt == 8'(LEAD - 1)) begin
                    next_state   = mbc_pkg::MBC_PD_SHIFT;
                    next_cnt     = 8'h00;
                    next_pd_load = 1'b0;
                end
            end
            mbc_pkg::MBC_PD_SHIFT: begin
                // clock high in second half
                next_pd_shift_clock = (next_cnt >= 8'(BIT_CYCLES / 2)) &&
                                      (next_cnt != 8'(BIT_CYCLES));
                if (cnt == 8'(BIT_CYCLES - 1)) begin
                    next_pd_data        = {pd_serial_data, pd_data[31:1]};
                    next_cnt            = 8'h00;
                    next_bits           = bits + 6'h01;
                    next_pd_shift_clock = 1'b0;
                    if (bits == 6'(`MBC_PD_BITS - 1)) begin
                        next_state    = mbc_pkg::MBC_PD_DONE;
                        next_pd_valid = 1'b1;
                    end
                end
            end
            mbc_pkg::MBC_PD_DONE: begin
                next_cnt = cnt;
            end
            default: begin
                next_state = mbc_pkg::MBC_PD_DONE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state          <= mbc_pkg::MBC_PD_LEAD;
            cnt            <= 8'h00;
            bits           <= 6'h00;
            pd_data        <= 32'h0000_0000;
            pd_load        <= 1'b0;
            pd_shift_clock <= 1'b0;
            pd_valid       <= 1'b0;
        end else begin
            state          <= next_state;
            cnt            <= next_cnt;
            bits           <= next_bits;
            pd_data        <= next_pd_data;
            pd_load        <= next_pd_load;
            pd_shift_clock <= next_pd_shift_clock;
            pd_valid       <= next_pd_valid;
        end
    end
endmodule : mbc_pd_shift
`default_nettype wire

// ---- test/mbc_pd_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mbc_pd_model #(
    parameter logic [31:0] PATTERN = 32'h5A5A_0FF0 // arbitrary strap pattern
) (
    input  wire logic mclk,
    input  wire logic pd_load,
    input  wire logic pd_shift_clock,
    output logic      pd_serial_data
);
    int   idx;
    logic clk_q;
    // step on falling shift edge; bit steady at rising
    always_ff @(posedge mclk) begin
        clk_q <= pd_shift_clock;
        if (pd_load) idx <= 0;
        else if (clk_q && !pd_shift_clock) idx <= idx + 1;
    end
    assign pd_serial_data = (idx < 32) ? PATTERN[idx] : ~PATTERN[31];
endmodule : mbc_pd_model
`default_nettype wire

// ---- test/mbc_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module mbc_top_chk (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        refresh_active,
    input wire logic        serial_load_active,
    input wire logic [8:0]  bank_select,
    input wire logic        bank_hit,
    input wire logic        bank_miss,
    input wire logic [8:0]  primary_row_strobe_n,
    input wire logic [8:0]  secondary_row_strobe_n,
    input wire logic [6:0]  serial_column_address
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_hit_miss: assert property (!(bank_hit && bank_miss))
        else $error("hit and miss together");
    a_select_hit: assert property (bank_hit == (bank_select != 9'h0) && $onehot0(bank_select))
        else $error("select not one hot");
    a_strobe_idle: assert property (!$past(refresh_active) && !$past(serial_load_active)
        && !bank_hit |-> &primary_row_strobe_n && &secondary_row_strobe_n)
        else $error("strobe without cause");
    a_strobe_owner: assert property (!$past(refresh_active) && !$past(serial_load_active)
        |-> (~primary_row_strobe_n & ~bank_select) == 9'h0)
        else $error("strobe on wrong bankset");
    a_col_align: assert property (serial_column_address[1:0] == 2'h0)
        else $error("serial column low bits set");
    c_hit: cover property (bank_hit);
    c_miss: cover property (bank_miss);
    c_video: cover property (secondary_row_strobe_n[8] == 1'h0);
endmodule : mbc_top_chk
bind mbc_top mbc_top_chk u_mbc_top_chk (.*);
`default_nettype wire

// ---- test/test_memory_bankset_config_decode.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_memory_bankset_config_decode;
    localparam logic [31:0] PD = 32'hC3A5_1E69;
    logic mclk = '0, sys_rst = '1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, row_strobe_request = '0, refresh_active = '0;
    logic serial_load_start = '0, serial_load_active = '0, memory_width_pin = '1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF, row_address_bits, column_address_bits;
    logic [33:0] system_address = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [8:0] bank_select, primary_row_strobe_n, secondary_row_strobe_n, serial_row_address;
    logic [6:0] serial_column_address;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bank_hit;
    logic bank_miss, subset_select, error_check_active, pd_serial_data, pd_load, pd_shift_clock;
    int miscompares = 0, total_checks = 0, cyc = 0, rel;
    // address, hit, subset, strobes low
    logic [37:0] rows [4] = '{{34'h008000000, 4'hA}, {34'h008400000, 4'hD},
                              {34'h0087FFFFC, 4'hD}, {34'h00C000000, 4'h0}};
    mbc_top u_mbc_top (.*);
    mbc_pd_model #(.PATTERN(PD)) u_mbc_pd_model (.*);
    initial forever #5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk); s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= '1; s_axi_wvalid <= '1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        s_axi_bready <= '1;
        do @(posedge mclk); while (!s_axi_bvalid);
        s_axi_bready <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge mclk); s_axi_araddr <= a; s_axi_arvalid <= '1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= '0; s_axi_rready <= '1;
        do @(posedge mclk); while (!s_axi_rvalid);
        v = s_axi_rdata; e = s_axi_rresp; s_axi_rready <= '0;
    endtask : rd
    // full serial transfer
    task automatic ser(input logic [17:0] e);
        @(posedge mclk); serial_load_start <= '1; serial_load_active <= '1;
        @(posedge mclk); serial_load_start <= '0;
        @(posedge mclk); @(negedge mclk);
        chk({serial_column_address, serial_row_address, secondary_row_strobe_n[8],
             primary_row_strobe_n[8]}, e);
        @(posedge mclk); serial_load_active <= '0;
    endtask : ser
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= '0; rel = cyc;
        @(posedge mclk);
        rd(8'h0C, d, r); chk(d[0], 0);
        rd(8'h10, d, r); chk(d[0], 0);
        rd(8'hFC, d, r); chk(r, 2);
        repeat (80) begin rd(8'h0C, d, r); if (d[0]) break; end
        chk(cyc - rel >= 148, 1);
        rd(8'h04, d, r); chk(d, PD[15:0]);
        rd(8'h08, d, r); chk(d, PD[31:16]);
        wr(8'h40, 32'h80); wr(8'h10, 32'h2F); wr(8'h60, 32'h100); wr(8'h30, 32'h333);
        rd(8'h10, d, r); chk(d, 32'h2F);
        row_strobe_request <= '1;
        foreach (rows[i]) begin
            @(posedge mclk); system_address <= rows[i][37:4];
            @(posedge mclk); @(negedge mclk);
            chk({bank_hit, subset_select, ~primary_row_strobe_n[0], ~secondary_row_strobe_n[0],
                 bank_miss}, {rows[i][3:0], ~rows[i][3]});
            if (i == 0) chk({row_address_bits, column_address_bits, error_check_active}, 9'h199);
        end
        @(posedge mclk); row_strobe_request <= '0; refresh_active <= '1;
        @(posedge mclk); @(negedge mclk);
        chk({primary_row_strobe_n[8], secondary_row_strobe_n[8], primary_row_strobe_n[1:0],
             secondary_row_strobe_n[0]}, 5'h04);
        @(posedge mclk); refresh_active <= '0;
        wr(8'h00, 32'h5475);
        ser({7'h54, 9'h0A3, 2'h1});
        wr(8'h00, 32'h1060); @(negedge mclk); chk(serial_column_address, 7'h54);
        ser({7'h00, 9'h083, 2'h2});
        wr(8'h10, 32'h2E); row_strobe_request <= '1; system_address <= 34'h008000000;
        @(posedge mclk); @(negedge mclk);
        chk({bank_hit, bank_miss, primary_row_strobe_n[0]}, 3'h3);
        test_done();
    end
endmodule : test_memory_bankset_config_decode
`default_nettype wire
